// *** rtl/tsd_pkg.sv ***
// types shared by the tile status and debug bank
`default_nettype none
package tsd_pkg;
  typedef logic [31:0] tsd_word_type;
  typedef logic [15:0] tsd_count_type;
  typedef enum logic [1:0] {
    TSD_IDLE = 2'b00,
    TSD_CAPTURE = 2'b01,
    TSD_IN_DEBUG = 2'b11
  } tsd_state_type;
endpackage : tsd_pkg
`default_nettype wire

// *** rtl/tsd_regs.svh ***
// register numbers, field positions and reset values of the status bank
`ifndef TSD_REGS_SVH
`define TSD_REGS_SVH
`define TSD_OFS_OSC_CTRL 8'h06
`define TSD_OFS_CCELL_CNT 8'h07
`define TSD_OFS_CWIRE_CNT 8'h08
`define TSD_OFS_PCELL_CNT 8'h09
`define TSD_OFS_PWIRE_CNT 8'h0A
`define TSD_OFS_MEM_SIZE 8'h0C
`define TSD_OFS_SAVED_STATUS 8'h10
`define TSD_OFS_SAVED_PC 8'h11
`define TSD_OFS_SAVED_SP 8'h12
`define TSD_OFS_READ_THREAD 8'h13
`define TSD_OFS_READ_REG 8'h14
`define TSD_OFS_IRQ_CAUSE 8'h15
`define TSD_OFS_IRQ_PAYLOAD 8'h16
`define TSD_OFS_THREAD_HOLD 8'h18
`define TSD_OFS_MAILBOX_LO 8'h20
`define TSD_OFS_MAILBOX_HI 8'h27
`define TSD_BIT_CORE_OSC_EN 1
`define TSD_BIT_PERI_OSC_EN 0
`define TSD_MASK_CNT 32'h0000_FFFF
`define TSD_MASK_MEM_SIZE 32'hFFFF_FFFC
`define TSD_MASK_STATUS_WR 32'h0000_06DF
`define TSD_MASK_STATUS_RD 32'h0000_07DF
`define TSD_BIT_STATUS_ISSUE 8
`define TSD_MASK_THREAD 32'h0000_00FF
`define TSD_MASK_REGNUM 32'h0000_001F
`define TSD_MASK_CAUSE 32'h0003_FF07
`define TSD_CAUSE_RESET 32'h0000_0000
`define TSD_CAUSE_HOST 3'h1
`define TSD_CAUSE_CALL 3'h2
`define TSD_CAUSE_IBREAK 3'h3
`define TSD_CAUSE_DWATCH 3'h4
`define TSD_CAUSE_RWATCH 3'h5
`define TSD_MASK_HOLD 32'h0000_00FF
`define TSD_ZERO32 32'h0000_0000
`define TSD_SETTLE_CYCLES 4'h3
`endif

// *** rtl/tsd_status_bank.sv ***
// tile processor-status register bank: entropy counters and debug state
//
// Behaviour
// - four running oscillators clock counters; control starts/stops them
// - control bit 1 enables core oscillators, bit 0 peripheral ones; reset 0
// - read-only counts, bits 15:0: core cell/wire, periph cell/wire
// - oscillator counts survive system reset
// - asynchronous oscillators; counts synchronised to the core clock
// - memory-size register reports tile memory bytes in bits 31:2
// - entry captures saved status bits 10:6 and 4:0; bit 8 read-only issue mode
// - status 4:0: kernel, handler, event sequence, irq enable, event enable
// - status bit 7 fast mode, bit 6 paused waiting
// - debug entry captures saved program counter
// - debug entry captures saved stack pointer
// - register-read operand one holds thread number in bits 7:0
// - register-read operand two holds register number in bits 4:0
// - cause field 2:0 encodes host, call, ibreak, data watch, resource watch
// - bits 17:16 hold lowest firing break index; zero for host and call
// - bits 15:8 hold causing thread; zero for host
// - payload captures data address or resource id on watchpoints
// - per-thread hold bits 7:0 stop threads outside debug mode
// - eight mailbox words shared with the tile configuration space
// - four each of instruction breakpoints, data watches and resource watches supply the recorded break index
`include "tsd_regs.svh"
`default_nettype none
module tsd_status_bank #(
  parameter int CNT_W = 16,
  parameter logic [31:0] MEM_BYTES = 32'h0002_0000
) (
  input wire logic mclk_in,
  input wire logic rst_in,
  // ring oscillator clocks: core cell, core wire, periph cell, periph wire
  input wire logic [3:0] osc_clk_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire logic [7:0] addr_in,
  input wire tsd_pkg::tsd_word_type wdata_in,
  output tsd_pkg::tsd_word_type rdata_out,
  output logic rvalid_out,
  input wire logic debug_mode_in,
  input wire logic debug_entry_in,
  input wire logic host_req_in,
  input wire logic call_instr_in,
  input wire logic [3:0] ibreak_hit_in,
  input wire logic [3:0] dwatch_hit_in,
  input wire logic [3:0] rwatch_hit_in,
  input wire logic [7:0] cause_thread_in,
  input wire tsd_pkg::tsd_word_type data_addr_in,
  input wire tsd_pkg::tsd_word_type resource_id_in,
  input wire tsd_pkg::tsd_word_type status_in,
  input wire tsd_pkg::tsd_word_type pc_in,
  input wire tsd_pkg::tsd_word_type sp_in,
  input wire logic cfg_wr_in,
  input wire logic [2:0] cfg_idx_in,
  input wire tsd_pkg::tsd_word_type cfg_wdata_in,
  output tsd_pkg::tsd_word_type cfg_rdata_out,
  output logic core_osc_en_out,
  output logic periph_osc_en_out,
  output logic [7:0] thread_hold_out,
  output logic [7:0] read_thread_out,
  output logic [4:0] read_reg_out
);
  import tsd_pkg::*;

  function automatic logic [1:0] lowest_idx(input logic [3:0] hits);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = 3; i >= 0; i--) begin
      if (hits[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction : lowest_idx

  function automatic tsd_count_type bin2gray(input tsd_count_type bin);
    return bin ^ (bin >> 1);
  endfunction : bin2gray

  function automatic tsd_count_type gray2bin(input tsd_count_type code);
    tsd_count_type bin;
    bin = code;
    for (int i = $bits(tsd_count_type) - 2; i >= 0; i--) begin
      bin[i] = bin[i + 1] ^ code[i];
    end
    return bin;
  endfunction : gray2bin

  // oscillator domains: gray-coded counters on their own clocks, no reset
  logic [3:0] osc_en;
  tsd_count_type osc_gray [4];
  tsd_count_type cnt_sync1 [4];
  tsd_count_type cnt_sync2 [4];
  tsd_count_type cnt_bin [4];
  logic core_en_r, core_en_nxt;
  logic peri_en_r, peri_en_nxt;

  assign osc_en = {peri_en_r, peri_en_r, core_en_r, core_en_r};

  for (genvar g = 0; g < 4; g++) begin : g_osc
    logic en_sync1_r, en_sync2_r;
    tsd_count_type gray_r = 16'h0000; // power-up value, reset never clears
    tsd_count_type gray_nxt;
    always_comb begin
      gray_nxt = gray_r;
      if (en_sync2_r) begin
        gray_nxt = bin2gray(gray2bin(gray_r) + 16'h0001);
      end
    end
    always_ff @(posedge osc_clk_in[g]) begin
      en_sync1_r <= osc_en[g];
      en_sync2_r <= en_sync1_r;
      gray_r <= gray_nxt;
    end
    assign osc_gray[g] = gray_r;
  end

  // one bit moves per count, so two stages sample a clean word
  always_ff @(posedge mclk_in) begin
    for (int i = 0; i < 4; i++) begin
      cnt_sync1[i] <= osc_gray[i];
      cnt_sync2[i] <= cnt_sync1[i];
    end
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      cnt_bin[i] = gray2bin(cnt_sync2[i]);
    end
  end

  // debug state
  tsd_state_type state_r, state_nxt;
  tsd_word_type status_r, status_nxt;
  tsd_word_type pc_r, pc_nxt;
  tsd_word_type sp_r, sp_nxt;
  tsd_word_type thr_r, thr_nxt;
  tsd_word_type regn_r, regn_nxt;
  tsd_word_type cause_r, cause_nxt;
  tsd_word_type payload_r, payload_nxt;
  tsd_word_type hold_r, hold_nxt;
  tsd_word_type mbox_r [8];
  tsd_word_type mbox_nxt [8];
  tsd_word_type rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  tsd_word_type cfg_rdata_r;
  logic dwr;

  assign dwr = wr_en_in & debug_mode_in;

  always_comb begin
    logic [2:0] code;
    logic [1:0] idx;
    code = 3'h0;
    idx = 2'h0;
    state_nxt = state_r;
    core_en_nxt = core_en_r;
    peri_en_nxt = peri_en_r;
    status_nxt = status_r;
    pc_nxt = pc_r;
    sp_nxt = sp_r;
    thr_nxt = thr_r;
    regn_nxt = regn_r;
    cause_nxt = cause_r;
    payload_nxt = payload_r;
    hold_nxt = hold_r;
    mbox_nxt = mbox_r;
    case (state_r)
      TSD_IDLE: begin
        if (debug_entry_in) begin
          state_nxt = TSD_CAPTURE;
        end
      end
      TSD_CAPTURE: begin
        state_nxt = TSD_IN_DEBUG;
      end
      TSD_IN_DEBUG: begin
        if (!debug_mode_in) begin
          state_nxt = TSD_IDLE;
        end
      end
      default: begin
        state_nxt = TSD_IDLE;
      end
    endcase
    if (wr_en_in && addr_in == `TSD_OFS_OSC_CTRL) begin
      core_en_nxt = wdata_in[`TSD_BIT_CORE_OSC_EN];
      peri_en_nxt = wdata_in[`TSD_BIT_PERI_OSC_EN];
    end
    if (dwr) begin
      case (addr_in)
        `TSD_OFS_SAVED_STATUS: begin
          status_nxt = (wdata_in & `TSD_MASK_STATUS_WR)
                     | (status_r & ~`TSD_MASK_STATUS_WR);
        end
        `TSD_OFS_SAVED_PC: begin
          pc_nxt = wdata_in;
        end
        `TSD_OFS_SAVED_SP: begin
          sp_nxt = wdata_in;
        end
        `TSD_OFS_READ_THREAD: begin
          thr_nxt = wdata_in & `TSD_MASK_THREAD;
        end
        `TSD_OFS_READ_REG: begin
          regn_nxt = wdata_in & `TSD_MASK_REGNUM;
        end
        `TSD_OFS_IRQ_CAUSE: begin
          cause_nxt = wdata_in & `TSD_MASK_CAUSE;
        end
        `TSD_OFS_IRQ_PAYLOAD: begin
          payload_nxt = wdata_in;
        end
        `TSD_OFS_THREAD_HOLD: begin
          hold_nxt = wdata_in & `TSD_MASK_HOLD;
        end
        default: begin
          if (addr_in >= `TSD_OFS_MAILBOX_LO &&
              addr_in <= `TSD_OFS_MAILBOX_HI) begin
            mbox_nxt[addr_in[2:0]] = wdata_in;
          end
        end
      endcase
    end
    if (cfg_wr_in) begin
      mbox_nxt[cfg_idx_in] = cfg_wdata_in;
    end
    // capture on entry overrides software writes in the same cycle
    if (state_r == TSD_IDLE && debug_entry_in) begin
      status_nxt = status_in & `TSD_MASK_STATUS_RD;
      pc_nxt = pc_in;
      sp_nxt = sp_in;
      if (host_req_in) begin
        code = `TSD_CAUSE_HOST;
      end else if (call_instr_in) begin
        code = `TSD_CAUSE_CALL;
      end else if (|ibreak_hit_in) begin
        code = `TSD_CAUSE_IBREAK;
        idx = lowest_idx(ibreak_hit_in);
      end else if (|dwatch_hit_in) begin
        code = `TSD_CAUSE_DWATCH;
        idx = lowest_idx(dwatch_hit_in);
        payload_nxt = data_addr_in;
      end else if (|rwatch_hit_in) begin
        code = `TSD_CAUSE_RWATCH;
        idx = lowest_idx(rwatch_hit_in);
        payload_nxt = resource_id_in;
      end
      cause_nxt = {14'h0000, idx,
                   host_req_in ? 8'h00 : cause_thread_in,
                   5'h00, code};
    end
  end

  always_comb begin
    rvalid_nxt = rd_en_in;
    rdata_nxt = `TSD_ZERO32;
    if (rd_en_in) begin
      case (addr_in)
        `TSD_OFS_OSC_CTRL: rdata_nxt = {30'h0000_0000, core_en_r, peri_en_r};
        `TSD_OFS_CCELL_CNT: rdata_nxt = {16'h0000, cnt_bin[0]};
        `TSD_OFS_CWIRE_CNT: rdata_nxt = {16'h0000, cnt_bin[1]};
        `TSD_OFS_PCELL_CNT: rdata_nxt = {16'h0000, cnt_bin[2]};
        `TSD_OFS_PWIRE_CNT: rdata_nxt = {16'h0000, cnt_bin[3]};
        `TSD_OFS_MEM_SIZE: rdata_nxt = MEM_BYTES & `TSD_MASK_MEM_SIZE;
        `TSD_OFS_SAVED_STATUS: rdata_nxt = status_r;
        `TSD_OFS_SAVED_PC: rdata_nxt = pc_r;
        `TSD_OFS_SAVED_SP: rdata_nxt = sp_r;
        `TSD_OFS_READ_THREAD: rdata_nxt = thr_r;
        `TSD_OFS_READ_REG: rdata_nxt = regn_r;
        `TSD_OFS_IRQ_CAUSE: rdata_nxt = cause_r;
        `TSD_OFS_IRQ_PAYLOAD: rdata_nxt = payload_r;
        `TSD_OFS_THREAD_HOLD: rdata_nxt = hold_r;
        default: begin
          if (addr_in >= `TSD_OFS_MAILBOX_LO &&
              addr_in <= `TSD_OFS_MAILBOX_HI) begin
            rdata_nxt = mbox_r[addr_in[2:0]];
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      state_r <= TSD_IDLE;
      core_en_r <= 1'b0;
      peri_en_r <= 1'b0;
      status_r <= `TSD_ZERO32;
      pc_r <= `TSD_ZERO32;
      sp_r <= `TSD_ZERO32;
      thr_r <= `TSD_ZERO32;
      regn_r <= `TSD_ZERO32;
      cause_r <= `TSD_CAUSE_RESET;
      payload_r <= `TSD_ZERO32;
      hold_r <= `TSD_ZERO32;
      for (int i = 0; i < 8; i++) begin
        mbox_r[i] <= `TSD_ZERO32;
      end
      rdata_r <= `TSD_ZERO32;
      rvalid_r <= 1'b0;
      cfg_rdata_r <= `TSD_ZERO32;
    end else begin
      state_r <= state_nxt;
      core_en_r <= core_en_nxt;
      peri_en_r <= peri_en_nxt;
      status_r <= status_nxt;
      pc_r <= pc_nxt;
      sp_r <= sp_nxt;
      thr_r <= thr_nxt;
      regn_r <= regn_nxt;
      cause_r <= cause_nxt;
      payload_r <= payload_nxt;
      hold_r <= hold_nxt;
      mbox_r <= mbox_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      cfg_rdata_r <= mbox_r[cfg_idx_in];
    end
  end

  assign rdata_out = rdata_r;
  assign rvalid_out = rvalid_r;
  assign cfg_rdata_out = cfg_rdata_r;
  assign core_osc_en_out = core_en_r;
  assign periph_osc_en_out = peri_en_r;
  assign thread_hold_out = hold_r[7:0];
  assign read_thread_out = thr_r[7:0];
  assign read_reg_out = regn_r[4:0];

  default clocking cb_core @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  AST_OSC_CTRL_WRITE: assert property (
    wr_en_in && addr_in == `TSD_OFS_OSC_CTRL |=>
      core_osc_en_out == $past(wdata_in[`TSD_BIT_CORE_OSC_EN]) &&
      periph_osc_en_out == $past(wdata_in[`TSD_BIT_PERI_OSC_EN]))
    else $error("oscillator enable not written");

  AST_WRITE_NEEDS_DEBUG: assert property (
    wr_en_in && !debug_mode_in && !debug_entry_in &&
      addr_in == `TSD_OFS_THREAD_HOLD |=> $stable(thread_hold_out))
    else $error("hold bits changed outside debug mode");

  sequence s_entry;
    state_r == TSD_IDLE && debug_entry_in;
  endsequence

  sequence s_break_entry;
    s_entry ##0 (!host_req_in && !call_instr_in);
  endsequence

  AST_PC_CAPTURE: assert property (
    s_entry |=> pc_r == $past(pc_in) && sp_r == $past(sp_in))
    else $error("saved pc or sp not captured");

  AST_HOST_CAUSE: assert property (
    s_entry and host_req_in |=> cause_r == 32'h0000_0001)
    else $error("host cause encoding wrong");

  AST_IBREAK_INDEX: assert property (
    s_break_entry ##0 (ibreak_hit_in != 4'h0) |=>
      cause_r[2:0] == `TSD_CAUSE_IBREAK &&
      (($past(ibreak_hit_in) >> cause_r[17:16]) & 4'h1) == 4'h1 &&
      ($past(ibreak_hit_in) & ((4'h1 << cause_r[17:16]) - 4'h1)) == 4'h0)
    else $error("lowest breakpoint not recorded");

  AST_DWATCH_DATA: assert property (
    s_break_entry ##0 (ibreak_hit_in == 4'h0 && dwatch_hit_in != 4'h0)
      |=> payload_r == $past(data_addr_in))
    else $error("watch address not captured");

  AST_CALL_INDEX_ZERO: assert property (
    s_entry ##0 (host_req_in || call_instr_in) |=> cause_r[17:16] == 2'h0)
    else $error("break index set for host or call entry");

  AST_STATUS_RSVD: assert property (
    ##1 status_r[31:11] == 21'h0 && status_r[5] == 1'b0)
    else $error("reserved status bits set");

  AST_READ_LATENCY: assert property (
    rd_en_in && addr_in == `TSD_OFS_THREAD_HOLD |=>
      rvalid_out && rdata_out == $past(hold_r))
    else $error("hold register read wrong");

  AST_MAILBOX_CFG: assert property (
    cfg_wr_in |=> mbox_r[$past(cfg_idx_in)] == $past(cfg_wdata_in))
    else $error("mailbox word not written from config side");
endmodule : tsd_status_bank
`default_nettype wire

// *** verif/tsd_osc_model.sv ***
// free-running ring oscillator sources seen by the status bank
`default_nettype none
module tsd_osc_model (
  output logic [3:0] osc_clk_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial osc_clk_out = 4'h0;
  // unrelated half periods keep counts asynchronous to the core clock
  always #1.3 osc_clk_out[0] = ~osc_clk_out[0];
  always #1.7 osc_clk_out[1] = ~osc_clk_out[1];
  always #2.9 osc_clk_out[2] = ~osc_clk_out[2];
  always #3.1 osc_clk_out[3] = ~osc_clk_out[3];
endmodule : tsd_osc_model
`default_nettype wire

// *** verif/tsd_status_bank_tb_top.sv ***
// self-checking bench for the tile status and debug bank
`default_nettype none
module tsd_status_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  import tsd_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, dbg = 1'b0;
  logic ent = 1'b0, hreq = 1'b0, call = 1'b0, cwr = 1'b0;
  logic rvalid, coe, poe;
  logic [7:0] addr = 8'h00, thr = 8'h00, hold, rthr;
  logic [3:0] ib = 4'h0, dw = 4'h0, rw = 4'h0, osc;
  logic [2:0] cidx = 3'h0;
  logic [4:0] rreg;
  tsd_word_type wd = '0, cwd = '0, st = '0, pc = '0, sp = '0;
  tsd_word_type da = 32'hDA7A_0004, rid = 32'h0005_0E51, rdata, crd, v;
  tsd_word_type p[4], q[4];
  int error_cnt = 0, checks_done = 0;
  logic [1:0] hc[5] = '{2'h3, 2'h1, 2'h0, 2'h0, 2'h0};
  logic [3:0] ibt[5] = '{4'hF, 4'h8, 4'h6, 4'h0, 4'h0};
  logic [3:0] dwt[5] = '{4'h0, 4'h0, 4'h1, 4'h8, 4'h0};
  logic [3:0] rwt[5] = '{4'h0, 4'h0, 4'h0, 4'h1, 4'hC};
  logic [1:0] ix[5] = '{2'h0, 2'h0, 2'h1, 2'h3, 2'h2};
  logic [7:0] ta[8] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h15, 8'h16,
    8'h18};
  tsd_word_type tm[8] = '{32'h0000_07DF, '1, '1, 32'h0000_00FF,
    32'h0000_001F, 32'h0003_FF07, '1, 32'h0000_00FF};

  always #2 mclk = ~mclk;

  tsd_osc_model tsd_osc_model_inst (.osc_clk_out(osc));

  tsd_status_bank #(.MEM_BYTES(32'h0001_0003)) tsd_status_bank_inst (
    .mclk_in(mclk), .rst_in(rst), .osc_clk_in(osc), .wr_en_in(wr),
    .rd_en_in(rd), .addr_in(addr), .wdata_in(wd), .rdata_out(rdata),
    .rvalid_out(rvalid), .debug_mode_in(dbg), .debug_entry_in(ent),
    .host_req_in(hreq), .call_instr_in(call), .ibreak_hit_in(ib),
    .dwatch_hit_in(dw), .rwatch_hit_in(rw), .cause_thread_in(thr),
    .data_addr_in(da), .resource_id_in(rid), .status_in(st), .pc_in(pc),
    .sp_in(sp), .cfg_wr_in(cwr), .cfg_idx_in(cidx), .cfg_wdata_in(cwd),
    .cfg_rdata_out(crd), .core_osc_en_out(coe), .periph_osc_en_out(poe),
    .thread_hold_out(hold), .read_thread_out(rthr), .read_reg_out(rreg)
  );

  task automatic report_and_stop();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input tsd_word_type s, input tsd_word_type e);
    checks_done++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : tick

  task automatic wr_reg(input logic [7:0] a, input tsd_word_type d);
    wr = 1'b1;
    addr = a;
    wd = d;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, output tsd_word_type d);
    int n;
    n = 0;
    rd = 1'b1;
    addr = a;
    tick(1);
    rd = 1'b0;
    while (rvalid !== 1'b1 && n < 4) begin
      tick(1);
      n++;
    end
    if (n == 4) begin
      error_cnt++;
      report_and_stop();
    end
    d = rdata;
    tick(1);
  endtask : rd_reg

  task automatic rchk(input logic [7:0] a, input tsd_word_type e);
    tsd_word_type d;
    rd_reg(a, d);
    chk(d, e);
  endtask : rchk

  // run the chosen oscillators, stop them, let counts settle, read all
  task automatic run_osc(input tsd_word_type en);
    p = q;
    wr_reg(8'h06, en);
    tick(50);
    wr_reg(8'h06, '0);
    tick(12);
    for (int i = 0; i < 4; i++) rd_reg(8'h07 + 8'(i), q[i]);
  endtask : run_osc

  initial begin
    tick(4);
    rst = 1'b0;
    rchk(8'h06, '0);
    rchk(8'h15, '0);
    chk({30'h0, coe, poe}, '0);
    rchk(8'h0C, 32'h0001_0000);
    rchk(8'h0B, '0);
    wr_reg(8'h18, '1);
    rchk(8'h18, '0);
    wr_reg(8'h06, '1);
    rchk(8'h06, 32'h0000_0003);
    chk({30'h0, coe, poe}, 32'h0000_0003);
    run_osc(32'h0000_0003);
    for (int i = 0; i < 4; i++) chk(q[i] & 32'hFFFF_0000, '0);
    run_osc(32'h0000_0002);
    for (int i = 0; i < 4; i++) begin
      chk({31'h0, q[i] != p[i]}, {31'h0, i < 2});
    end
    run_osc(32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      chk({31'h0, q[i] != p[i]}, {31'h0, i > 1});
    end
    for (int k = 0; k < 2; k++) begin
      rst = k[0];
      tick(4);
      rst = 1'b0;
      for (int i = 0; i < 4; i++) begin
        rd_reg(8'h07 + 8'(i), v);
        chk(v, q[i]);
      end
    end
    for (int i = 0; i < 5; i++) begin
      {hreq, call} = hc[i];
      ib = ibt[i];
      dw = dwt[i];
      rw = rwt[i];
      thr = 8'hA5;
      st = i[0] ? '1 : 32'h0000_0120;
      pc = 32'h1000_0000 + 32'(i);
      sp = 32'h2000_0000 + 32'(i);
      ent = 1'b1;
      tick(1);
      ent = 1'b0;
      dbg = 1'b1;
      tick(1);
      rchk(8'h10, i[0] ? 32'h0000_07DF : 32'h0000_0100);
      rchk(8'h11, pc);
      rchk(8'h12, sp);
      v = {14'h0, ix[i], hc[i][1] ? 8'h00 : thr, 5'h0, 3'(i + 1)};
      rchk(8'h15, v);
      if (i > 2) rchk(8'h16, i == 3 ? da : rid);
      if (i < 4) begin
        dbg = 1'b0;
        tick(2);
      end
    end
    for (int i = 0; i < 8; i++) begin
      wr_reg(ta[i], '1);
      rchk(ta[i], tm[i]);
    end
    chk({hold, rthr, 11'h0, rreg}, 32'hFFFF_001F);
    wr_reg(8'h10, '0);
    rchk(8'h10, 32'h0000_0100);
    for (int i = 0; i < 8; i++) wr_reg(8'h20 + 8'(i), {8{4'(i)}});
    cwr = 1'b1;
    cidx = 3'h5;
    cwd = 32'hC0DE_0005;
    tick(1);
    cwr = 1'b0;
    cidx = 3'h2;
    tick(1);
    chk(crd, 32'h2222_2222);
    for (int i = 0; i < 8; i++) begin
      v = i == 5 ? cwd : {8{4'(i)}};
      rchk(8'h20 + 8'(i), v);
    end
    dbg = 1'b0;
    tick(2);
    wr_reg(8'h18, '0);
    rchk(8'h18, 32'h0000_00FF);
    report_and_stop();
  end
endmodule : tsd_status_bank_tb_top
`default_nettype wire
